// ===== bench/ccc_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module ccc_switch_model (
  input  wire logic [3:0] position_in,
  output logic [3:0]      switch_out
);
  // Contacts need no settling here; the block synchronises the pins
  assign switch_out = position_in;
endmodule // ccc_switch_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccc_params.svh"
module testbench;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [3:0]  sw_pos;
  logic [3:0]  sw_pin;
  logic [3:0]  rate;
  logic [9:0]  kbps;
  logic        busy;
  logic        halt;
  int          errors;
  int          tests_run;
  logic [31:0] rd;
  logic        sl;
  logic [9:0]  kb_tab [0:8];
  logic [3:0]  sw_set [0:2];
  logic [3:0]  sw_exp [0:2];
  logic [31:0] cob    [0:3];

  ccc_switch_model ccc_switch_model_inst (.position_in(sw_pos), .switch_out(sw_pin));
  ccc_cmd_handler #(.NUM_REGS(32), .REG_AW(5)) ccc_cmd_handler_inst (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .RATE_SWITCH_IN(sw_pin),
    .CAN_RATE_OUT(rate), .CAN_KBPS_OUT(kbps), .CMD_BUSY_OUT(busy), .PROG_HALT_OUT(halt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Pready is sampled before the edge's own updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic se);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      close_out();
    end
    d = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        se;
    apb(1'b1, a, wd, d, se);
  endtask

  task automatic rdr(input logic [11:0] a, output logic [31:0] d);
    logic se;
    apb(1'b0, a, 32'h0, d, se);
  endtask

  function automatic logic [11:0] ureg(input int n);
    return `CCC_OFF_UREG + 12'(4 * n);
  endfunction

  task automatic cmd(input logic [15:0] code, input logic [31:0] p0, input logic [31:0] p1,
                     input logic [31:0] p2, input logic [31:0] p3, input logic err);
    logic [31:0] st;
    int          n;
    wr(`CCC_OFF_CMD, {16'h0000, code});
    wr(`CCC_OFF_P0, p0);
    wr(`CCC_OFF_P1, p1);
    wr(`CCC_OFF_P2, p2);
    wr(`CCC_OFF_P3, p3);
    wr(`CCC_OFF_CTRL, 32'h0000_0001);
    st = 32'h0;
    n = 0;
    while (st[2:1] == 2'b00 && n < 40) begin
      rdr(`CCC_OFF_STAT, st);
      n++;
    end
    if (n >= 40) begin
      errors++;
      close_out();
    end
    check("cmd_error", {31'h0, st[1]}, {31'h0, err});
    check("prog_halt", {31'h0, halt}, {31'h0, err});
    check("busy_end", {31'h0, busy}, 32'h0);
    wr(`CCC_OFF_STAT, 32'h0000_0006);
  endtask

  task automatic getobj(input logic [15:0] idx, input logic [7:0] sub, input int n,
                        output logic [31:0] d);
    cmd(`CCC_CODE_LOCAL, 32'h0, 32'(n), {16'h0, idx}, {24'h0, sub}, 1'b0);
    rdr(ureg(n), d);
  endtask

  // A refused command must leave the running rate alone
  task automatic bad(input logic [15:0] code, input logic [31:0] p0, input logic [31:0] p1,
                     input logic [31:0] p2, input logic [31:0] p3);
    cmd(code, p0, p1, p2, p3, 1'b1);
    check("rate_kept", {28'h0, rate}, 32'h4);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sw_pos = 4'h0;
    errors = 0;
    tests_run = 0;
    kb_tab = '{10'h3E8, 10'h320, 10'h1F4, 10'h0FA, 10'h07D, 10'h064, 10'h032, 10'h014, 10'h00A};
    sw_set = '{4'h5, 4'h9, 4'hF};
    sw_exp = '{4'h5, 4'h0, 4'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("rate_rst", {28'h0, rate}, 32'h0);
    check("kbps_rst", {22'h0, kbps}, 32'h3E8);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      cmd(`CCC_CODE_RATE, 32'(i), 32'h0, 32'h0, 32'h0, 1'b0);
      check("rate_code", {28'h0, rate}, 32'(i));
      check("rate_kbps", {22'h0, kbps}, {22'h0, kb_tab[i]});
    end
    $display("test rate codes done");
    for (int i = 0; i < 3; i++) begin
      sw_pos <= sw_set[i];
      repeat (6) @(posedge clk);
      cmd(`CCC_CODE_RATE, 32'h0000_00FF, 32'h0, 32'h0, 32'h0, 1'b0);
      check("sw_rate", {28'h0, rate}, {28'h0, sw_exp[i]});
      rdr(`CCC_OFF_RATE, rd);
      check("sw_field", {28'h0, rd[15:12]}, {28'h0, sw_set[i]});
      getobj(`CCC_IDX_SWITCH, 8'h00, 7, rd);
      check("sw_object", {28'h0, rd[7:4]}, {28'h0, sw_set[i]});
    end
    $display("test rotary switch done");
    cmd(`CCC_CODE_RATE, 32'h4, 32'h0, 32'h0, 32'h0, 1'b0);
    bad(`CCC_CODE_RATE, 32'h9, 32'h0, 32'h0, 32'h0);
    bad(`CCC_CODE_RATE, 32'hFE, 32'h0, 32'h0, 32'h0);
    bad(`CCC_CODE_LOCAL, 32'h3, 32'h4, 32'h1006, 32'h0);
    bad(`CCC_CODE_LOCAL, 32'h2, 32'h5, 32'h200A, 32'h0);
    bad(`CCC_CODE_LOCAL, 32'h2, 32'h5, 32'h1280, 32'h0);
    bad(`CCC_CODE_LOCAL, 32'h0, 32'h4, 32'h1000, 32'h0);
    bad(`CCC_CODE_LOCAL, 32'h0, 32'h20, 32'h1006, 32'h0);
    bad(`CCC_CODE_LOCAL, 32'h0, 32'h1F, 32'h2010, 32'h0);
    bad(16'h0049, 32'h0, 32'h0, 32'h0, 32'h0);
    bad(`CCC_CODE_CONNECT, 32'h0, 32'h1, 32'h0, 32'h0);
    bad(`CCC_CODE_CONNECT, 32'h5, 32'h3, 32'h0, 32'h0);
    $display("test command errors done");
    cmd(`CCC_CODE_LOCAL, 32'h2, 32'h0000_03E8, 32'h1006, 32'h0, 1'b0);
    getobj(`CCC_IDX_SYNC, 8'h00, 4, rd);
    check("const_copy", rd, 32'h0000_03E8);
    wr(ureg(5), 32'hA5A5_1234);
    cmd(`CCC_CODE_LOCAL, 32'h1, 32'h5, 32'h1006, 32'h0, 1'b0);
    getobj(`CCC_IDX_SYNC, 8'h00, 6, rd);
    check("reg_copy", rd, 32'hA5A5_1234);
    wr(ureg(10), 32'h1111_2222);
    wr(ureg(11), 32'h3333_4444);
    cmd(`CCC_CODE_LOCAL, 32'h1, 32'hA, 32'h2010, 32'h0, 1'b0);
    getobj(`CCC_IDX_TOD, 8'h00, 20, rd);
    check("tod_low", rd, 32'h1111_2222);
    rdr(ureg(21), rd);
    check("tod_high", rd, 32'h3333_4444);
    $display("test local access done");
    // Boundary node ids: highest on client 1, lowest on client 2
    for (int c = 1; c < 3; c++) begin
      cob = '{32'h3, (c == 1) ? 32'h67F : 32'h601, (c == 1) ? 32'h5FF : 32'h581,
              (c == 1) ? 32'h7F : 32'h01};
      cmd(`CCC_CODE_CONNECT, cob[3], 32'(c), 32'h0, 32'h0, 1'b0);
      for (int s = 0; s < 4; s++) begin
        getobj(16'h1280 + 16'(c - 1), 8'(s), 24, rd);
        check("client_obj", rd, cob[s]);
      end
    end
    $display("test connect done");
    apb(1'b0, 12'h0FC, 32'h0, rd, sl);
    check("unmapped_err", {31'h0, sl}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    $display("test unmapped done");
    close_out();
  end
endmodule // testbench
`default_nettype wire

// ===== hw/ccc_cmd_handler.sv
// What this block does
// - After reset the CAN interface runs at 1 Mb/s.
// - Rate code 0..8 selects 1000,800,500,250,125,100,50,20,10 kb/s.
// - Reserved code 5 still runs at 100 kb/s.
// - Code 255 takes rate from switch; positions 9..F mean 1 Mb/s.
// - Switch setting readable in bits 4..7 of object 200Ah.
// - Rate command is code 71, two words; 71 0 gives 1 Mb/s.
// - Connect command sets client 1 or 2 to the remote default server.
// - Connect writes object 1280h or 1281h in three local writes.
// - Local read copies object to register; write copies register or constant.
// - Mode 0 reads, 1 writes from register, 2 writes constant.
// - Second parameter is register number in modes 0,1; constant in 2.
// - Objects addressed by 16-bit index and 8-bit sub-index.
// - Local access is code 72: mode, data, index, sub-index; five words.
// - Invalid dictionary access flags command error and halts the program.
// - Time-of-day objects move through two consecutive registers.
`timescale 1ns/100ps
`default_nettype none
`include "ccc_params.svh"
module ccc_cmd_handler
  import ccc_pkg::*;
#(
  parameter int NUM_REGS = 32,
  parameter int REG_AW   = 5
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic [31:0]      PRDATA_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic [3:0]  RATE_SWITCH_IN,
  output logic [3:0]       CAN_RATE_OUT,
  output logic [9:0]       CAN_KBPS_OUT,
  output logic             CMD_BUSY_OUT,
  output logic             PROG_HALT_OUT
);
  function automatic logic [9:0] rate_kbps(input logic [3:0] code);
    case (code)
      4'h1:    rate_kbps = 10'd800;
      4'h2:    rate_kbps = 10'd500;
      4'h3:    rate_kbps = 10'd250;
      4'h4:    rate_kbps = 10'd125;
      4'h5:    rate_kbps = 10'd100;
      4'h6:    rate_kbps = 10'd50;
      4'h7:    rate_kbps = 10'd20;
      4'h8:    rate_kbps = 10'd10;
      default: rate_kbps = 10'd1000;
    endcase
  endfunction

  function automatic logic dict_valid(input logic [15:0] idx,
                                      input logic [15:0] sub,
                                      input logic        wr);
    case (idx)
      `CCC_IDX_CLIENT1,
      `CCC_IDX_CLIENT2: dict_valid = (sub >= 16'h0001 && sub <= 16'h0003) ||
                                     (sub == 16'h0000 && !wr);
      `CCC_IDX_SYNC,
      `CCC_IDX_TOD:     dict_valid = (sub == 16'h0000);
      `CCC_IDX_SWITCH:  dict_valid = (sub == 16'h0000) && !wr;
      default:          dict_valid = 1'b0;
    endcase
  endfunction

  ccc_state_t   state_q, state_d;
  logic [1:0]   step_q, step_d;
  logic [15:0]  cmd_q;
  logic [31:0]  p0_q, p1_q, p2_q, p3_q;
  logic [7:0]   rate_sel_q;
  logic [3:0]   eff_d, eff_q;
  logic [9:0]   kbps_q;
  logic         err_q, done_q;
  logic [3:0]   sw_s1_q, sw_s2_q, sw_s3_q, sw_q;
  logic [31:0]  cli_q [6];
  logic [31:0]  sync_q, tod_lo_q, tod_hi_q;
  logic [31:0]  dict_rdata, prdata_q, mem_rdata;
  logic         wait_q, ureg_rd_q;
  ccc_dict_wr_t dwr;
  ccc_mem_req_t mreq;
  logic         rate_set;

  // APB decode
  wire        acc       = PSEL_IN && PENABLE_IN;
  wire        busy      = (state_q != S_IDLE);
  wire        is_ureg   = (PADDR_IN >= `CCC_OFF_UREG) &&
                          (PADDR_IN < 12'(`CCC_OFF_UREG + 4 * NUM_REGS));
  wire        is_param  = (PADDR_IN >= `CCC_OFF_CMD) && (PADDR_IN <= `CCC_OFF_P3);
  wire        aligned   = (PADDR_IN[1:0] == 2'b00);
  wire        is_reg    = (PADDR_IN <= `CCC_OFF_RATE) || is_ureg;
  wire        mapped    = aligned && is_reg;
  // Command words are frozen while a command runs
  wire        stall     = busy && mapped && (is_ureg || (is_param && PWRITE_IN));
  wire        first     = acc && !wait_q && !stall;
  wire        wr_fire   = PREADY_OUT && PWRITE_IN && mapped;
  wire [7:0]  ureg_addr = 8'((PADDR_IN - `CCC_OFF_UREG) >> 2);
  wire        go        = wr_fire && (PADDR_IN == `CCC_OFF_CTRL) &&
                          PWDATA_IN[`CCC_CTRL_GO];
  wire        stat_wr   = wr_fire && (PADDR_IN == `CCC_OFF_STAT);

  assign PREADY_OUT  = acc && wait_q;
  assign PSLVERR_OUT = PREADY_OUT && !mapped;
  assign PRDATA_OUT  = ureg_rd_q ? mem_rdata : prdata_q;

  // Command field views
  wire [15:0] mode     = p0_q[15:0];
  wire [15:0] idx      = p2_q[15:0];
  wire [15:0] sub      = p3_q[15:0];
  wire [7:0]  reg_n    = p1_q[7:0];
  wire [7:0]  reg_n1   = 8'(p1_q[7:0] + 8'h01);
  wire        is_tod   = (idx == `CCC_IDX_TOD);
  wire        mode_ok  = (mode <= 16'h0002);
  wire        reg_ok   = (mode == 16'h0002) ||
                         (p1_q < (32'(NUM_REGS) - {31'h0, is_tod}));
  wire        local_ok = mode_ok && reg_ok &&
                         dict_valid(idx, sub, mode != 16'h0000);
  wire        rate_ok  = (p0_q[15:0] <= {8'h00, `CCC_RATE_MAX}) ||
                         (p0_q[15:0] == {8'h00, `CCC_RATE_SWITCH});
  wire [15:0] node_id  = p0_q[15:0];
  wire [15:0] client   = p1_q[15:0];
  wire        conn_ok  = (node_id >= 16'h0001) && (node_id <= `CCC_NODE_MAX) &&
                         (client == 16'h0001 || client == 16'h0002);
  wire [31:0] node32   = {16'h0000, node_id};
  wire [15:0] cli_idx  = (client == 16'h0002) ? `CCC_IDX_CLIENT2 : `CCC_IDX_CLIENT1;
  wire [7:0]  combo_sub = {6'h00, step_q} + 8'h01;
  wire [31:0] combo_val = (step_q == 2'd0) ? `CCC_COB_TO_SRV + node32 :
                          (step_q == 2'd1) ? `CCC_COB_FROM_SRV + node32 : node32;
  wire [2:0]  wr_slot  = 3'((dwr.idx == `CCC_IDX_CLIENT2) ? 3 : 0) +
                         3'(dwr.sub - 8'h01);
  wire [2:0]  rd_slot  = 3'((idx == `CCC_IDX_CLIENT2) ? 3 : 0) + 3'(sub - 16'h0001);

  // Dictionary read mux
  always_comb begin
    dict_rdata = 32'h0;
    case (idx)
      `CCC_IDX_CLIENT1,
      `CCC_IDX_CLIENT2: dict_rdata = (sub == 16'h0000) ? `CCC_CLI_SUBS : cli_q[rd_slot];
      `CCC_IDX_SYNC:    dict_rdata = sync_q;
      `CCC_IDX_TOD:     dict_rdata = tod_lo_q;
      `CCC_IDX_SWITCH:  dict_rdata = {24'h0, sw_q, 4'h0};
      default:          dict_rdata = 32'h0;
    endcase
  end

  // Command sequencer
  always_comb begin
    state_d  = state_q;
    step_d   = step_q;
    rate_set = 1'b0;
    dwr      = '0;
    mreq     = '0;
    case (state_q)
      S_IDLE: begin
        if (go) begin
          state_d = S_EXEC;
        end
        mreq.re    = first && is_ureg && aligned && !PWRITE_IN;
        mreq.we    = wr_fire && is_ureg;
        mreq.addr  = ureg_addr;
        mreq.wdata = PWDATA_IN;
      end
      S_EXEC: begin
        case (cmd_q)
          `CCC_CODE_RATE: begin
            rate_set = rate_ok;
            state_d  = rate_ok ? S_DONE : S_ERR;
          end
          `CCC_CODE_LOCAL: begin
            dwr.idx = idx;
            dwr.sub = sub[7:0];
            if (!local_ok) begin
              state_d = S_ERR;
            end else if (mode == 16'h0000) begin
              mreq.we    = 1'b1;
              mreq.addr  = reg_n;
              mreq.wdata = dict_rdata;
              state_d    = is_tod ? S_WRHI : S_DONE;
            end else if (mode == 16'h0001) begin
              mreq.re   = 1'b1;
              mreq.addr = reg_n;
              state_d   = S_MRD;
            end else begin
              dwr.en   = 1'b1;
              dwr.data = p1_q;
              state_d  = S_DONE;
            end
          end
          `CCC_CODE_CONNECT: begin
            step_d  = 2'd0;
            state_d = conn_ok ? S_COMBO : S_ERR;
          end
          default: state_d = S_ERR;
        endcase
      end
      S_MRD: begin
        dwr.en   = 1'b1;
        dwr.idx  = idx;
        dwr.sub  = sub[7:0];
        dwr.data = mem_rdata;
        if (is_tod) begin
          mreq.re   = 1'b1;
          mreq.addr = reg_n1;
          state_d   = S_MRD2;
        end else begin
          state_d = S_DONE;
        end
      end
      S_MRD2: begin
        dwr.en   = 1'b1;
        dwr.idx  = idx;
        dwr.hi   = 1'b1;
        dwr.data = mem_rdata;
        state_d  = S_DONE;
      end
      S_WRHI: begin
        mreq.we    = 1'b1;
        mreq.addr  = reg_n1;
        mreq.wdata = tod_hi_q;
        state_d    = S_DONE;
      end
      S_COMBO: begin
        dwr.en   = 1'b1;
        dwr.idx  = cli_idx;
        dwr.sub  = combo_sub;
        dwr.data = combo_val;
        step_d   = 2'(step_q + 2'd1);
        if (step_q == 2'd2) begin
          state_d = S_DONE;
        end
      end
      S_DONE:  state_d = S_IDLE;
      S_ERR:   state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  ccc_user_mem #(
    .DEPTH (NUM_REGS),
    .AW    (REG_AW)
  ) u_mem (
    .clk_in    (CORE_CLK_IN),
    .req_in    (mreq),
    .rdata_out (mem_rdata)
  );

  // Effective rate; reserved code 5 kept for non-CANopen buses
  assign eff_d = (rate_sel_q == `CCC_RATE_SWITCH) ?
                 ((sw_q <= 4'h8) ? sw_q : 4'h0) : rate_sel_q[3:0];

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      state_q    <= S_IDLE;
      step_q     <= 2'd0;
      rate_sel_q <= `CCC_RATE_RST;
      eff_q      <= 4'h0;
      kbps_q     <= 10'd1000;
      sw_s1_q    <= 4'h0;
      sw_s2_q    <= 4'h0;
      sw_s3_q    <= 4'h0;
      sw_q       <= 4'h0;
    end else begin
      state_q    <= state_d;
      step_q     <= step_d;
      if (rate_set) begin
        rate_sel_q <= p0_q[7:0];
      end
      eff_q      <= eff_d;
      kbps_q     <= rate_kbps(eff_d);
      sw_s1_q    <= RATE_SWITCH_IN;
      sw_s2_q    <= sw_s1_q;
      sw_s3_q    <= sw_s2_q;
      if (sw_s2_q == sw_s3_q) begin
        sw_q <= sw_s3_q;
      end
    end
  end

  // Sticky flags: hardware set wins over software clear
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      err_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      err_q  <= (state_q == S_ERR) ||
                (err_q && !(stat_wr && PWDATA_IN[`CCC_STAT_ERR]));
      done_q <= (state_q == S_DONE) ||
                (done_q && !(stat_wr && PWDATA_IN[`CCC_STAT_DONE]));
    end
  end

  // Command words and APB read data
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      cmd_q     <= 16'h0;
      p0_q      <= 32'h0;
      p1_q      <= 32'h0;
      p2_q      <= 32'h0;
      p3_q      <= 32'h0;
      wait_q    <= 1'b0;
      ureg_rd_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      if (wr_fire && PADDR_IN == `CCC_OFF_CMD) cmd_q <= PWDATA_IN[15:0];
      if (wr_fire && PADDR_IN == `CCC_OFF_P0)  p0_q  <= PWDATA_IN;
      if (wr_fire && PADDR_IN == `CCC_OFF_P1)  p1_q  <= PWDATA_IN;
      if (wr_fire && PADDR_IN == `CCC_OFF_P2)  p2_q  <= PWDATA_IN;
      if (wr_fire && PADDR_IN == `CCC_OFF_P3)  p3_q  <= PWDATA_IN;
      wait_q    <= first || (wait_q && !PREADY_OUT);
      if (first) begin
        ureg_rd_q <= is_ureg && aligned;
        case (PADDR_IN)
          `CCC_OFF_CMD:  prdata_q <= {16'h0, cmd_q};
          `CCC_OFF_P0:   prdata_q <= p0_q;
          `CCC_OFF_P1:   prdata_q <= p1_q;
          `CCC_OFF_P2:   prdata_q <= p2_q;
          `CCC_OFF_P3:   prdata_q <= p3_q;
          `CCC_OFF_STAT: prdata_q <= {29'h0, done_q, err_q, busy};
          `CCC_OFF_RATE: prdata_q <= {16'h0, sw_q, eff_q, rate_sel_q};
          default:       prdata_q <= 32'h0;
        endcase
      end
    end
  end

  // Dictionary storage; objects left for a network master to set
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      for (int i = 0; i < 6; i++) begin
        cli_q[i] <= 32'h0;
      end
      sync_q   <= 32'h0;
      tod_lo_q <= 32'h0;
      tod_hi_q <= 32'h0;
    end else if (dwr.en) begin
      case (dwr.idx)
        `CCC_IDX_CLIENT1,
        `CCC_IDX_CLIENT2: cli_q[wr_slot] <= dwr.data;
        `CCC_IDX_SYNC:    sync_q <= dwr.data;
        `CCC_IDX_TOD: begin
          if (dwr.hi) tod_hi_q <= dwr.data;
          else        tod_lo_q <= dwr.data;
        end
        default: ;
      endcase
    end
  end

  assign CAN_RATE_OUT  = eff_q;
  assign CAN_KBPS_OUT  = kbps_q;
  assign CMD_BUSY_OUT  = busy;
  assign PROG_HALT_OUT = err_q;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  wire exec_rate  = (state_q == S_EXEC) && (cmd_q == `CCC_CODE_RATE);
  wire exec_local = (state_q == S_EXEC) && (cmd_q == `CCC_CODE_LOCAL);
  wire exec_conn  = (state_q == S_EXEC) && (cmd_q == `CCC_CODE_CONNECT);

  sequence combo_writes_s;
    (dwr.en && state_q == S_COMBO)[*3];
  endsequence

  default_rate_a: assert property ((rate_sel_q == `CCC_RATE_RST) |=>
    (CAN_RATE_OUT == 4'h0) && (CAN_KBPS_OUT == 10'd1000))
    else $error("default rate not 1 Mb/s");
  rate_table_a: assert property ((exec_rate && p0_q[15:0] == 16'h0001) |->
    ##2 (CAN_KBPS_OUT == 10'd800))
    else $error("code 1 did not give 800 kb/s");
  rate_reserved_a: assert property ((rate_sel_q == 8'h05) |=>
    (CAN_KBPS_OUT == 10'd100))
    else $error("code 5 did not give 100 kb/s");
  switch_high_a: assert property ((rate_sel_q == 8'hFF && sw_q > 4'h8) |=>
    (CAN_RATE_OUT == 4'h0))
    else $error("switch 9..F not 1 Mb/s");
  switch_dict_a: assert property ((idx == `CCC_IDX_SWITCH) |->
    (dict_rdata[7:4] == sw_q) && (dict_rdata[3:0] == 4'h0))
    else $error("switch bits misplaced");
  rate_reject_a: assert property ((exec_rate && !rate_ok) |=>
    (state_q == S_ERR) && $stable(rate_sel_q) ##1 PROG_HALT_OUT)
    else $error("bad rate code not rejected");
  combo_three_a: assert property ((exec_conn && conn_ok) |=>
    combo_writes_s ##1 (state_q == S_DONE))
    else $error("connect not three writes");
  local_halt_a: assert property ((exec_local && !local_ok) |->
    ##2 (PROG_HALT_OUT && !CMD_BUSY_OUT))
    else $error("invalid access did not halt");
  tod_pair_a: assert property ((exec_local && local_ok && is_tod &&
    mode == 16'h0000) |-> mreq.we ##1 (mreq.we && mreq.addr == $past(mreq.addr) + 8'h01))
    else $error("time of day not two registers");
  const_write_a: assert property ((exec_local && local_ok &&
    mode == 16'h0002) |-> (dwr.en && dwr.data == p1_q) ##1 (state_q == S_DONE))
    else $error("constant write wrong");
endmodule // ccc_cmd_handler
`default_nettype wire

// ===== hw/ccc_params.svh
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH
// APB byte offsets
`define CCC_OFF_CTRL     12'h000
`define CCC_OFF_CMD      12'h004
`define CCC_OFF_P0       12'h008
`define CCC_OFF_P1       12'h00C
`define CCC_OFF_P2       12'h010
`define CCC_OFF_P3       12'h014
`define CCC_OFF_STAT     12'h018
`define CCC_OFF_RATE     12'h01C
`define CCC_OFF_UREG     12'h100
// Field positions
`define CCC_CTRL_GO      0
`define CCC_STAT_BUSY    0
`define CCC_STAT_ERR     1
`define CCC_STAT_DONE    2
`define CCC_SW_LSB       4
// Command codes
`define CCC_CODE_RATE    16'h0047
`define CCC_CODE_LOCAL   16'h0048
`define CCC_CODE_CONNECT 16'h00F0
// Rate codes and reset values
`define CCC_RATE_RST     8'h00
`define CCC_RATE_MAX     8'h08
`define CCC_RATE_SWITCH  8'hFF
`define CCC_NODE_MAX     16'h007F
// Dictionary objects
`define CCC_IDX_CLIENT1  16'h1280
`define CCC_IDX_CLIENT2  16'h1281
`define CCC_IDX_SYNC     16'h1006
`define CCC_IDX_SWITCH   16'h200A
`define CCC_IDX_TOD      16'h2010
`define CCC_CLI_SUBS     32'h0000_0003
`define CCC_COB_TO_SRV   32'h0000_0600
`define CCC_COB_FROM_SRV 32'h0000_0580
`endif

// ===== hw/ccc_pkg.sv
package ccc_pkg;
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_EXEC  = 8'h02,
    S_MRD   = 8'h04,
    S_MRD2  = 8'h08,
    S_WRHI  = 8'h10,
    S_COMBO = 8'h20,
    S_DONE  = 8'h40,
    S_ERR   = 8'h80
  } ccc_state_t;

  typedef struct packed {
    logic        en;
    logic [15:0] idx;
    logic [7:0]  sub;
    logic        hi;
    logic [31:0] data;
  } ccc_dict_wr_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ccc_mem_req_t;
endpackage

// ===== hw/ccc_user_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ccc_user_mem
  import ccc_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic         clk_in,
  input  wire ccc_mem_req_t req_in,
  output var  logic [31:0]  rdata_out
);
  logic [31:0] mem_q [DEPTH];

  // Read data registered; one cycle latency
  always_ff @(posedge clk_in) begin
    if (req_in.we) begin
      mem_q[req_in.addr[AW-1:0]] <= req_in.wdata;
    end
    if (req_in.re) begin
      rdata_out <= mem_q[req_in.addr[AW-1:0]];
    end
  end
endmodule // ccc_user_mem
`default_nettype wire
